// ===== inc/spb_pkg.sv
// shared constants and types for the switch port bridge control block
package spb_pkg;

  // register word addresses (byte offsets, all multiples of four)
  localparam logic [7:0] SPB_OFS_BRCTL   = 8'h3C;
  localparam logic [7:0] SPB_OFS_PMCAP   = 8'h40;
  localparam logic [7:0] SPB_OFS_CAPPTR  = 8'h34;
  localparam logic [7:0] SPB_OFS_DECODE  = 8'h80;
  localparam logic [7:0] SPB_OFS_DECRES  = 8'h84;
  localparam logic [7:0] SPB_OFS_LOAD    = 8'h88;
  localparam logic [7:0] SPB_OFS_WINHI   = 8'h8C;

  // bridge control field positions in the 3Ch dword
  localparam int SPB_BIT_PERR   = 16;
  localparam int SPB_BIT_SERR   = 17;
  localparam int SPB_BIT_ISA    = 18;
  localparam int SPB_BIT_VGA    = 19;
  localparam int SPB_BIT_VGA16  = 20;
  localparam int SPB_BIT_SBRST  = 22;
  localparam int SPB_BIT_RSVLO  = 28;

  // power management capability constants
  localparam logic [7:0]  SPB_PM_CAPID   = 8'h01;
  localparam logic [7:0]  SPB_NEXT_UP    = 8'h5C;
  localparam logic [7:0]  SPB_NEXT_DN    = 8'h4C;
  localparam logic [2:0]  SPB_PM_REV     = 3'h3;
  localparam logic [7:0]  SPB_CAP_PTR    = 8'h40;
  localparam logic        SPB_DSI_RST    = 1'h0;
  localparam logic [2:0]  SPB_AUX_RST    = 3'h7;
  localparam logic [1:0]  SPB_D1D2_RST   = 2'h3;
  localparam logic [4:0]  SPB_PME_RST    = 5'h1F;

  // legacy display and ISA decode constants
  localparam logic [31:0] SPB_VGA_MLO  = 32'h000A_0000;
  localparam logic [31:0] SPB_VGA_MHI  = 32'h000B_FFFF;
  localparam logic [9:0]  SPB_VIO_ALO  = 10'h3B0;
  localparam logic [9:0]  SPB_VIO_AHI  = 10'h3BB;
  localparam logic [9:0]  SPB_VIO_BLO  = 10'h3C0;
  localparam logic [9:0]  SPB_VIO_BHI  = 10'h3DF;
  localparam logic [9:0]  SPB_ISA_TOP  = 10'h100;
  localparam logic [15:0] SPB_IO64K_HI = 16'h0000;

  // read-only capability fields that a sideband loader may override
  typedef struct packed {
    logic [4:0] pmeSupport;
    logic [1:0] d1d2Support;
    logic [2:0] auxCurrent;
    logic       devSpecInit;
  } spb_pmfield_t;

  localparam spb_pmfield_t SPB_PMF_RST =
    '{SPB_PME_RST, SPB_D1D2_RST, SPB_AUX_RST, SPB_DSI_RST};

  // decode result flags
  typedef struct packed {
    logic fwdDown;
    logic fwdUp;
    logic vgaHit;
  } spb_route_t;

endpackage

// ===== core/spb_bridge_ctrl.sv
// bridge control and power management capability register bank of one port
`timescale 1ns/1ps

module spb_bridge_ctrl
  import spb_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b0,
  parameter int NUM_DOWN    = 2
)(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic [7:0]          avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [31:0]         avsWriteData,
  input  wire logic [3:0]          avsByteEnable,
  output logic      [31:0]         avsReadData,
  output logic                     avsWaitRequest,
  input  wire logic                pmLoadValid,
  input  wire spb_pmfield_t        pmLoadData,
  input  wire logic                upSecResetIn,
  output logic                     poisonDetectEn,
  output logic                     secondary_error_forward_enable,
  output logic                     hotResetReq,
  output logic      [NUM_DOWN-1:0] portRst_b,
  output spb_route_t               routeResult
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [6:0]   brCtl_q;    // bits 22:16 of 3Ch, bit 21 (index 5) held at zero
  logic [3:0]   brRsv_q;    // reserved 31:28, preserved
  spb_pmfield_t pmf_q;
  logic [31:0]  decAddr_q;  // address presented to the route decoder
  logic         decIsIo_q;  // 1 = I/O access, 0 = memory
  logic [31:0]  ioWinLo_q;
  logic [31:0]  ioWinHi_q;
  logic         ackPend_q;
  logic [1:0]   upRstSync_q;
  logic         wrHit;

  // byte-lane merge used by every writable register except decIsIo_q, which takes lane 0 alone
  function automatic logic [31:0] beMerge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // composed register images
  function automatic logic [31:0] brImage(input logic [6:0] c,
                                          input logic [3:0] rs);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[SPB_BIT_PERR]  = c[0];
    v[SPB_BIT_SERR]  = c[1];
    v[SPB_BIT_ISA]   = c[2];
    v[SPB_BIT_VGA]   = c[3];
    v[SPB_BIT_VGA16] = c[4];
    v[SPB_BIT_SBRST] = c[6];
    v[31:SPB_BIT_RSVLO] = rs;
    return v;
  endfunction

  logic [31:0] pmImage;
  logic [31:0] brNow;
  // capability header, read-only fields from the loaded copy
  always_comb begin
    pmImage        = 32'h0000_0000;
    pmImage[7:0]   = SPB_PM_CAPID;
    pmImage[15:8]  = IS_UPSTREAM ? SPB_NEXT_UP : SPB_NEXT_DN;
    pmImage[18:16] = SPB_PM_REV;
    pmImage[21]    = pmf_q.devSpecInit;
    pmImage[24:22] = pmf_q.auxCurrent;
    pmImage[26:25] = pmf_q.d1d2Support;
    pmImage[31:27] = pmf_q.pmeSupport;
  end
  assign brNow = brImage(brCtl_q, brRsv_q);

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ackPend_q <= 1'b0;
    end else begin
      ackPend_q <= (avsRead | avsWrite) & ~ackPend_q;
    end
  end
  // waitrequest from its own flop, high in reset and on the taking edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitRequest <= 1'b1;
    end else begin
      avsWaitRequest <= ~((avsRead | avsWrite) & avsWaitRequest);
    end
  end
  assign wrHit = avsWrite & ackPend_q;

  // read data, registered at the taking edge and held for the answering edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avsReadData <= 32'h0000_0000;
    end else if (avsRead & ~ackPend_q) begin
      unique case (avsAddress)
        SPB_OFS_CAPPTR: avsReadData <= {24'h000000, SPB_CAP_PTR};
        SPB_OFS_BRCTL:  avsReadData <= brNow;
        SPB_OFS_PMCAP:  avsReadData <= pmImage;
        SPB_OFS_DECODE: avsReadData <= decAddr_q;
        SPB_OFS_DECRES: avsReadData <= {28'h0000000, decIsIo_q,
                                        routeResult};
        default:        avsReadData <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridge control writes, upper half only, byte-lane granular
  always_ff @(posedge mclk or negedge rst_b) begin
    logic [31:0] m;
    if (!rst_b) begin
      brCtl_q <= 7'h00;
      brRsv_q <= 4'h0;
    end else if (wrHit && avsAddress == SPB_OFS_BRCTL) begin
      m = beMerge(brNow, avsWriteData, avsByteEnable);
      brCtl_q[0] <= m[SPB_BIT_PERR];
      brCtl_q[1] <= m[SPB_BIT_SERR];
      brCtl_q[2] <= m[SPB_BIT_ISA];
      brCtl_q[3] <= m[SPB_BIT_VGA];
      brCtl_q[4] <= m[SPB_BIT_VGA16];
      brCtl_q[5] <= 1'b0;
      brCtl_q[6] <= m[SPB_BIT_SBRST];
      brRsv_q    <= m[31:SPB_BIT_RSVLO];
    end
  end

  // decode probe and window registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      decAddr_q <= 32'h0000_0000;
      decIsIo_q <= 1'b0;
      ioWinLo_q <= 32'h0000_0000;
      ioWinHi_q <= 32'h0000_0000;
    end else if (wrHit) begin
      unique case (avsAddress)
        SPB_OFS_DECODE: decAddr_q <= beMerge(decAddr_q, avsWriteData,
                                             avsByteEnable);
        SPB_OFS_DECRES: decIsIo_q <= avsByteEnable[0] ? avsWriteData[3]
                                                      : decIsIo_q;
        SPB_OFS_LOAD:   ioWinLo_q <= beMerge(ioWinLo_q, avsWriteData,
                                             avsByteEnable);
        SPB_OFS_WINHI:  ioWinHi_q <= beMerge(ioWinHi_q, avsWriteData,
                                             avsByteEnable);
        default:        ;
      endcase
    end
  end

  // capability defaults, overridden by the sideband loader
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pmf_q <= SPB_PMF_RST;
    end else if (pmLoadValid) begin
      pmf_q <= pmLoadData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forwarding decision for the probed address
  logic inWin;
  logic isaHole;
  logic vgaIo;
  logic vgaMem;
  logic first64k;
  always_comb begin
    inWin    = decAddr_q >= ioWinLo_q && decAddr_q <= ioWinHi_q;
    first64k = decAddr_q[31:16] == SPB_IO64K_HI;
    // top 768 bytes of each 1KB block in the first 64KB: offset 100h..3FFh
    isaHole  = first64k && decAddr_q[9:0] >= SPB_ISA_TOP;
    vgaIo    = first64k
             && ((decAddr_q[9:0] >= SPB_VIO_ALO && decAddr_q[9:0] <= SPB_VIO_AHI)
              || (decAddr_q[9:0] >= SPB_VIO_BLO && decAddr_q[9:0] <= SPB_VIO_BHI))
             && (!brCtl_q[4] || decAddr_q[15:10] == 6'h00);
    vgaMem   = decAddr_q >= SPB_VGA_MLO && decAddr_q <= SPB_VGA_MHI;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      routeResult <= '0;
    end else begin
      routeResult.vgaHit  <= brCtl_q[3] & (decIsIo_q ? vgaIo : vgaMem);
      routeResult.fwdUp   <= decIsIo_q & inWin & brCtl_q[2] & isaHole
                           & ~(brCtl_q[3] & vgaIo);
      routeResult.fwdDown <= (decIsIo_q & inWin
                              & ~(brCtl_q[2] & isaHole))
                           | (brCtl_q[3] & decIsIo_q & vgaIo)
                           | (brCtl_q[3] & ~decIsIo_q & vgaMem);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upstream secondary reset level from another port, synchronised
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upRstSync_q <= 2'b00;
    end else begin
      upRstSync_q <= {upRstSync_q[0], upSecResetIn};
    end
  end

  // control outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      poisonDetectEn                 <= 1'b0;
      secondary_error_forward_enable <= 1'b0;
      hotResetReq                    <= 1'b0;
      portRst_b                      <= '1;
    end else begin
      poisonDetectEn                 <= brCtl_q[0];
      secondary_error_forward_enable <= brCtl_q[1];
      hotResetReq                    <= brCtl_q[6];
      if (IS_UPSTREAM) begin
        portRst_b <= {NUM_DOWN{~brCtl_q[6]}};
      end else begin
        portRst_b <= {NUM_DOWN{~(brCtl_q[6] | upRstSync_q[1])}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // bus handshake and read data
  a_write_ack: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer late");
  a_wait_single: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");
  a_read_capptr: assert property (
    @(posedge mclk) disable iff (!rst_b)
    avsRead && avsWaitRequest && avsAddress == SPB_OFS_CAPPTR
    |=> avsReadData == {24'h000000, SPB_CAP_PTR})
    else $error("capability pointer read wrong");
  a_read_pmcap: assert property (
    @(posedge mclk) disable iff (!rst_b)
    avsRead && avsWaitRequest && avsAddress == SPB_OFS_PMCAP
    |=> avsReadData == $past(pmImage))
    else $error("capability header read wrong");

  // bridge control bits and the outputs they drive
  a_reset_follows_bit: assert property (
    @(posedge mclk) disable iff (!rst_b)
    brCtl_q[6] |=> portRst_b == '0)
    else $error("port reset not asserted after secondary reset bit");
  a_hot_reset_out: assert property (
    @(posedge mclk) disable iff (!rst_b)
    hotResetReq == $past(brCtl_q[6]))
    else $error("hot reset request does not follow bit");
  a_port_release: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !brCtl_q[6] && !upRstSync_q[1] |=> portRst_b == '1)
    else $error("port reset held without cause");
  a_up_reset_fan: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !IS_UPSTREAM && upRstSync_q[1] |=> portRst_b == '0)
    else $error("upstream reset not fanned out");
  a_hardwired_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    brNow[21] == 1'b0 && brNow[27:23] == 5'h00)
    else $error("hardwired bridge control bits not zero");
  a_rsvd_written: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_BRCTL && avsByteEnable[3]
    |=> brRsv_q == $past(avsWriteData[31:28]))
    else $error("reserved bits not kept as written");
  a_rsvd_kept: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_BRCTL && !avsByteEnable[3]
    |=> $stable(brRsv_q))
    else $error("reserved bits changed by masked write");
  a_poison_enable: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_BRCTL && avsByteEnable[2]
    |=> ##1 poisonDetectEn == $past(avsWriteData[SPB_BIT_PERR], 2))
    else $error("poison enable does not follow write");
  a_poison_follow: assert property (
    @(posedge mclk) disable iff (!rst_b)
    poisonDetectEn == $past(brCtl_q[0]))
    else $error("poison enable mismatch");
  a_error_forward: assert property (
    @(posedge mclk) disable iff (!rst_b)
    secondary_error_forward_enable == $past(brCtl_q[1]))
    else $error("error forward enable mismatch");
  a_sbrst_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_BRCTL && avsByteEnable[2]
    |=> brCtl_q[6] == $past(avsWriteData[SPB_BIT_SBRST]))
    else $error("secondary reset bit does not follow write");
  a_lane_masked: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_BRCTL && !avsByteEnable[2]
    |=> $stable(brCtl_q))
    else $error("control bits changed by masked write");

  // capability header
  a_cap_header: assert property (
    @(posedge mclk) disable iff (!rst_b)
    pmImage[7:0] == SPB_PM_CAPID && pmImage[20:16] == 5'h03)
    else $error("capability header constant wrong");
  a_next_pointer: assert property (
    @(posedge mclk) disable iff (!rst_b)
    pmImage[15:8] == (IS_UPSTREAM ? SPB_NEXT_UP : SPB_NEXT_DN))
    else $error("next pointer wrong");
  a_loader_fields: assert property (
    @(posedge mclk) disable iff (!rst_b)
    pmLoadValid |=> pmImage[31:21] == $past(pmLoadData))
    else $error("loaded capability fields not shown");
  a_ro_ignored: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrHit && avsAddress == SPB_OFS_PMCAP && !pmLoadValid
    |=> $stable(pmf_q))
    else $error("read-only capability fields changed by write");

  // forwarding decision
  a_vga_memory: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !brCtl_q[3] && !decIsIo_q |=> !routeResult.fwdDown)
    else $error("display memory forwarded while disabled");
  a_vga_mem_fwd: assert property (
    @(posedge mclk) disable iff (!rst_b)
    brCtl_q[3] && !decIsIo_q && vgaMem
    |=> routeResult.fwdDown && routeResult.vgaHit)
    else $error("display memory not forwarded");
  a_isa_route: assert property (
    @(posedge mclk) disable iff (!rst_b)
    decIsIo_q && inWin && !brCtl_q[2] && !brCtl_q[3]
    |=> routeResult.fwdDown && !routeResult.fwdUp)
    else $error("window not forwarded downstream");
  a_isa_upstream: assert property (
    @(posedge mclk) disable iff (!rst_b)
    decIsIo_q && inWin && brCtl_q[2] && isaHole && !brCtl_q[3]
    |=> routeResult.fwdUp && !routeResult.fwdDown)
    else $error("legacy I/O hole not sent upstream");
  a_mem_no_up: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !decIsIo_q |=> !routeResult.fwdUp)
    else $error("memory access sent upstream");
  a_vga_io: assert property (
    @(posedge mclk) disable iff (!rst_b)
    brCtl_q[3] && decIsIo_q && vgaIo
    |=> routeResult.fwdDown && routeResult.vgaHit && !routeResult.fwdUp)
    else $error("display I/O not forwarded");
  a_vga16_decode: assert property (
    @(posedge mclk) disable iff (!rst_b)
    brCtl_q[4] && decAddr_q[15:10] != 6'h00 |-> !vgaIo)
    else $error("sixteen-bit display decode too wide");

endmodule

// ===== tb/spb_host_model.sv
// host model issuing configuration requests on the register bus
`timescale 1ns/1ps
module spb_host_model (
  input  wire logic        mclk,
  input  wire logic        avsWaitRequest,
  input  wire logic [31:0] avsReadData,
  output logic      [7:0]  avsAddress,
  output logic             avsRead,
  output logic             avsWrite,
  output logic      [31:0] avsWriteData,
  output logic      [3:0]  avsByteEnable
);
  // idle bus at time zero
  initial begin
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0000_0000;
    avsByteEnable = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one transfer, held until waitrequest is sampled low; released address
  // and write data lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rd);
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= w;
    avsRead <= !w;
    @(posedge mclk);
    while (avsWaitRequest !== 1'b0) begin
      @(posedge mclk);
    end
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    avsAddress <= ~a;
    avsWriteData <= ~d;
  endtask
endmodule

// ===== tb/test_spb_bridge_ctrl.sv
// self-checking bench for the bridge control register bank
`timescale 1ns/1ps
module test_spb_bridge_ctrl
  import spb_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst_b;
  logic [7:0]   avsAddress;
  logic         avsRead;
  logic         avsWrite;
  logic [31:0]  avsWriteData;
  logic [3:0]   avsByteEnable;
  logic [31:0]  avsReadData;
  logic         avsWaitRequest;
  logic         pmLoadValid;
  spb_pmfield_t pmLoadData;
  logic         upSecResetIn;
  logic         poisonDetectEn;
  logic         secondary_error_forward_enable;
  logic         hotResetReq;
  logic [1:0]   portRst_b;
  spb_route_t   routeResult;
  int           miscompares = 0;
  int           checks = 0;
  int           cycles = 0;
  // decode cases: ctl byte, isIo, address, flag mask, expected flags
  logic [51:0]  rt [12] = '{52'h00_1_00000100_6_4, 52'h04_1_00000100_6_2,
    52'h04_1_00000050_6_4, 52'h08_0_000A0000_1_1, 52'h08_0_000C0000_1_0,
    52'h00_0_000A0000_1_0, 52'h08_1_000003BB_1_1, 52'h08_1_000003BC_1_0,
    52'h08_1_000003DF_1_1, 52'h08_1_000007C0_1_1, 52'h18_1_000007C0_1_0,
    52'h18_1_000003C0_1_1};

  always #5 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  spb_bridge_ctrl #(.IS_UPSTREAM(1'b0), .NUM_DOWN(2)) dut (
    .mclk(mclk), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .pmLoadValid(pmLoadValid),
    .pmLoadData(pmLoadData), .upSecResetIn(upSecResetIn),
    .poisonDetectEn(poisonDetectEn),
    .secondary_error_forward_enable(secondary_error_forward_enable),
    .hotResetReq(hotResetReq), .portRst_b(portRst_b),
    .routeResult(routeResult));
  spb_host_model host (
    .mclk(mclk), .avsWaitRequest(avsWaitRequest),
    .avsReadData(avsReadData), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] x;
    host.xfer(1'b1, a, d, be, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0000_0000, 4'hF, d);
  endtask
  // outputs as a word: poison, error forward, hot reset, port resets
  function automatic logic [31:0] outs();
    return {27'h0, poisonDetectEn, secondary_error_forward_enable,
            hotResetReq, portRst_b};
  endfunction
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    rd(SPB_OFS_BRCTL, d);
    check(d & 32'h0FFF_0000, 32'h0000_0000);
    rd(SPB_OFS_PMCAP, d);
    check(d, 32'hFFC3_4C01);
    rd(SPB_OFS_CAPPTR, d);
    check(d & 32'h0000_00FF, 32'h0000_0040);
    check(outs(), 32'h0000_0003);
    $display("test reset done");
  endtask
  task automatic t_ctl;
    logic [31:0] d;
    wr(SPB_OFS_BRCTL, 32'hFFFF_0000, 4'hC);
    rd(SPB_OFS_BRCTL, d);
    check(d & 32'h0FFF_0000, 32'h005F_0000);
    check(outs(), 32'h0000_001C);
    wr(SPB_OFS_BRCTL, 32'h0000_0000, 4'h8);
    rd(SPB_OFS_BRCTL, d);
    check(d & 32'h0FFF_0000, 32'h005F_0000);
    wr(SPB_OFS_BRCTL, 32'h0000_0000, 4'h4);
    repeat (2) @(posedge mclk);
    check(outs(), 32'h0000_0003);
    $display("test control done");
  endtask
  task automatic t_ro;
    logic [31:0] d;
    wr(SPB_OFS_PMCAP, 32'h0000_0000, 4'hF);
    rd(SPB_OFS_PMCAP, d);
    check(d, 32'hFFC3_4C01);
    wr(8'hF0, 32'hFFFF_FFFF, 4'hF);
    rd(8'hF0, d);
    check(d, 32'h0000_0000);
    $display("test read-only done");
  endtask
  task automatic t_hot;
    int n;
    n = 0;
    @(posedge mclk);
    upSecResetIn <= 1'b1;
    while (portRst_b !== 2'b00 && n < 8) begin
      n++;
      @(posedge mclk);
    end
    check(outs(), 32'h0000_0000);
    upSecResetIn <= 1'b0;
    n = 0;
    while (portRst_b !== 2'b11 && n < 8) begin
      n++;
      @(posedge mclk);
    end
    check(outs(), 32'h0000_0003);
    $display("test upstream reset done");
  endtask
  task automatic t_route;
    logic [31:0] d;
    logic [51:0] e;
    wr(8'h88, 32'h0000_0000, 4'hF);
    wr(8'h8C, 32'h0000_FFFF, 4'hF);
    for (int i = 0; i < 12; i++) begin
      e = rt[i];
      wr(SPB_OFS_BRCTL, {8'h00, e[51:44], 16'h0000}, 4'h4);
      wr(SPB_OFS_DECODE, e[39:8], 4'hF);
      wr(SPB_OFS_DECRES, {28'h0, e[40], 3'b000}, 4'hF);
      rd(SPB_OFS_DECRES, d);
      check(d & e[7:4], e[3:0]);
      check(routeResult & e[6:4], e[2:0]);
    end
    wr(SPB_OFS_BRCTL, 32'h0000_0000, 4'h4);
    $display("test decode done");
  endtask
  task automatic t_load;
    logic [31:0] d;
    @(posedge mclk);
    pmLoadValid <= 1'b1;
    pmLoadData <= 11'h295;
    @(posedge mclk);
    pmLoadValid <= 1'b0;
    rd(SPB_OFS_PMCAP, d);
    check(d, {11'h295, 5'h03, 16'h4C01});
    $display("test loader done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    pmLoadValid = 1'b0;
    pmLoadData = 11'h000;
    upSecResetIn = 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_ctl();
    t_ro();
    t_hot();
    t_route();
    t_load();
    end_sim();
  end
endmodule
